// >>> rtl/stl_pkg.sv
// constants, carriers and helpers of the synchronous transmitter load/reset block
// assumes one 125 MHz clock and that every pin input is synchronous to it
package stl_pkg;

    // ------------------------------------------------------------
    // sizes and register map
    // ------------------------------------------------------------
    localparam int CHAR_W = 8;
    localparam int EV_W = 3;
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK = 2'h1;
    localparam logic [1:0] ADDR_STATE = 2'h2;
    localparam int EV_EMPTY = 0;
    localparam int EV_FILL = 1;
    localparam int EV_DONE = 2;
    localparam logic [7:0] FILL_INIT = 8'hff;
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] WLS_8 = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_DATA = 1'h1
    } stl_state_t;

    typedef struct packed {
        logic [1:0] wls;
        logic [1:0] cs;
        logic [1:0] ms;
        logic even;
        logic nopar;
    } stl_ctl_t;

    // every pin input, carried through one synchroniser so they stay aligned
    typedef struct packed {
        logic init;
        logic dis;
        logic txs;
        logic fls;
        logic clr;
        logic cld;
        logic cts;
        logic [7:0] tx;
        logic [7:0] fill;
        stl_ctl_t ctl;
    } stl_pins_t;

    typedef struct packed {
        stl_state_t state;
        stl_ctl_t ctl;
        logic [7:0] hold;
        logic hold_valid;
        logic [7:0] fill;
        logic [7:0] shreg;
        logic [3:0] left;
        logic empty;
        logic fill_sent;
        logic line;
        logic eoc_n;
        logic oe_n;
        logic init_d;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic [7:0] rdata;
    } stl_core_t;

    localparam stl_ctl_t CTL_RST = '{wls: WLS_8, cs: 2'h0, ms: MODE_SYNC,
        even: 1'b0, nopar: 1'b1};
    localparam stl_pins_t PINS_RST = '{init: 1'b0, dis: 1'b0, txs: 1'b1, fls: 1'b1,
        clr: 1'b1, cld: 1'b1, cts: 1'b0, tx: 8'h00, fill: 8'h00, ctl: CTL_RST};
    localparam stl_core_t CORE_RST = '{state: ST_IDLE, ctl: CTL_RST, hold: 8'h00,
        hold_valid: 1'b0, fill: FILL_INIT, shreg: 8'h00, left: 4'h0, empty: 1'b1,
        fill_sent: 1'b0, line: 1'b1, eoc_n: 1'b1, oe_n: 1'b0, init_d: 1'b0,
        status: 3'h0, mask: 3'h0, irq: 1'b0, rdata: 8'h00};

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bits per character: 5, 6, 7 or 8
    function automatic logic [3:0] stl_nbits(input logic [1:0] wls);
        stl_nbits = 4'h5 + {2'h0, wls};
    endfunction

    // keep only the least significant bits of a short character
    function automatic logic [7:0] stl_mask(input logic [7:0] ch, input logic [1:0] wls);
        case (wls)
            2'h0: stl_mask = {3'h0, ch[4:0]};
            2'h1: stl_mask = {2'h0, ch[5:0]};
            2'h2: stl_mask = {1'h0, ch[6:0]};
            default: stl_mask = ch;
        endcase
    endfunction

    // data bits then the optional parity bit, lsb first
    function automatic logic [8:0] stl_frame(input logic [7:0] ch, input stl_ctl_t c);
        logic [7:0] m;
        m = stl_mask(ch, c.wls);
        stl_frame = {1'b0, m};
        if (!c.nopar) begin
            stl_frame[stl_nbits(c.wls)] = c.even ? ^m : ~^m;
        end
    endfunction

    function automatic logic [3:0] stl_count(input stl_ctl_t c);
        stl_count = stl_nbits(c.wls) + {3'h0, ~c.nopar};
    endfunction

    // clock cycles per bit minus one: 1, 16, 32 or 64 cycles
    function automatic logic [5:0] stl_div_last(input logic [1:0] cs);
        case (cs)
            2'h0: stl_div_last = 6'h00;
            2'h1: stl_div_last = 6'h0f;
            2'h2: stl_div_last = 6'h1f;
            default: stl_div_last = 6'h3f;
        endcase
    endfunction

endpackage

// >>> rtl/stl_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes the bundle may be skewed by a cycle at most between its bits
`timescale 1ns/1ns
module stl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] s_reg;
    logic [1:0][W-1:0] s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next[0] = d;
        s_next[1] = s_reg[0];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= {RST, RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg[1];
endmodule

// >>> rtl/stl_bit_timer.sv
// bit rate divider: one-cycle tick every 1, 16, 32 or 64 clocks
// assumes restart is a one-cycle pulse from the core
`timescale 1ns/1ns
module stl_bit_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic restart,
    input wire logic [1:0] div_sel,
    output logic tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } stl_timer_t;

    stl_timer_t t_reg;
    stl_timer_t t_next;

    // a ratio change takes effect at once: each cycle compares the count with the new limit
    always_comb begin
        t_next = t_reg;
        t_next.tick = 1'b0;
        if (restart) begin
            t_next.cnt = 6'h00;
        end else if (t_reg.cnt >= stl_pkg::stl_div_last(div_sel)) begin
            t_next.cnt = 6'h00;
            t_next.tick = 1'b1;
        end else begin
            t_next.cnt = t_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t_reg <= '{cnt: 6'h00, tick: 1'b0};
        end else begin
            t_reg <= t_next;
        end
    end

    assign tick = t_reg.tick;
endmodule

// >>> rtl/stl_core.sv
// synchronous transmitter: holding registers, init, chip disable, serial line
// assumes pins are synchronous to clk and the host keeps each strobe low long
// enough for the synchronised copy to be seen for at least one cycle
`timescale 1ns/1ns
// Contract
// - rising global init returns the sequencing logic to idle.
// - global init sets empty flag, fill register to ones, serial line to mark.
// - low tx strobe makes hold register follow inputs and forces empty low.
// - high tx strobe freezes the hold register on its last character.
// - fill register follows its eight inputs while its strobe is low, else holds.
// - tx strobe only acts while chip disable is low.
// - fill strobe only acts while chip disable is low.
// - chip disable high floats the flag outputs and ignores busable inputs.
// - gated inputs are loads, clears, characters and selects; gated outputs are flags.
// - empty flag high means the character went to the shift register.
// - in sync mode with no new character the fill character is sent next.
// - short word lengths use only the low bits of a character.
module stl_core (
    input wire logic clk,
    input wire logic rstn,
    input wire logic global_init,
    input wire logic output_float_ctrl,
    input wire logic tx_hold_load_strobe,
    input wire logic fill_hold_load_strobe,
    input wire logic fill_flag_clear,
    input wire logic control_reg_load,
    input wire logic clear_to_send,
    input wire logic [7:0] tx_char_in,
    input wire logic [7:0] fill_char_in,
    input wire logic [1:0] word_length_sel,
    input wire logic [1:0] clock_divide_sel,
    input wire logic [1:0] tx_mode_sel,
    input wire logic even_parity_sel,
    input wire logic parity_inhibit,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic serial_tx_out,
    output logic end_of_char_n,
    output logic tx_hold_empty,
    output logic tx_hold_empty_oe_n,
    output logic fill_sent_flag,
    output logic fill_sent_flag_oe_n,
    output logic irq
);
    // ------------------------------------------------------------
    // input synchronisation and bit timing
    // ------------------------------------------------------------
    stl_pkg::stl_pins_t pins_raw;
    stl_pkg::stl_pins_t pins_s;
    stl_pkg::stl_core_t r;
    stl_pkg::stl_core_t n;
    logic tick;
    logic init_ev;
    logic ld_tx;
    logic ld_fill;
    logic ld_ctl;
    logic clr_fill;
    logic start_ok;
    logic char_end;
    logic take_hold;
    logic take_fill;
    logic [8:0] frame_hold;
    logic [8:0] frame_fill;

    // gather every pin so the whole bundle shares one latency
    assign pins_raw = '{init: global_init, dis: output_float_ctrl,
        txs: tx_hold_load_strobe, fls: fill_hold_load_strobe,
        clr: fill_flag_clear, cld: control_reg_load, cts: clear_to_send,
        tx: tx_char_in, fill: fill_char_in,
        ctl: '{wls: word_length_sel, cs: clock_divide_sel, ms: tx_mode_sel,
        even: even_parity_sel, nopar: parity_inhibit}};

    stl_sync #(
        .W($bits(stl_pkg::stl_pins_t)),
        .RST(stl_pkg::PINS_RST)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pins_raw),
        .q(pins_s)
    );

    stl_bit_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .restart(init_ev),
        .div_sel(r.ctl.cs),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // qualified strobes and shift decisions
    // ------------------------------------------------------------
    // init acts on the rising edge only
    assign init_ev = pins_s.init & ~r.init_d;
    assign ld_tx = ~pins_s.dis & ~pins_s.txs;
    assign ld_fill = ~pins_s.dis & ~pins_s.fls;
    assign ld_ctl = ~pins_s.dis & ~pins_s.cld;
    assign clr_fill = ~pins_s.dis & ~pins_s.clr;

    // a new character may start from idle or right after the last bit
    assign char_end = tick & (r.state == stl_pkg::ST_DATA) & (r.left == 4'h0);
    assign start_ok = tick & pins_s.cts & ~init_ev
        & ((r.state == stl_pkg::ST_IDLE) | (r.left == 4'h0));
    // an open latch is never handed over: the host is still writing it
    assign take_hold = start_ok & r.hold_valid & ~ld_tx;
    assign take_fill = start_ok & ~take_hold & (r.state == stl_pkg::ST_DATA)
        & (r.ctl.ms == stl_pkg::MODE_SYNC);
    assign frame_hold = stl_pkg::stl_frame(r.hold, r.ctl);
    assign frame_fill = stl_pkg::stl_frame(r.fill, r.ctl);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] ev;
        logic [3:0] cnt;
        ev = 3'h0;
        cnt = stl_pkg::stl_count(r.ctl);
        n = r;
        n.init_d = pins_s.init;
        n.rdata = 8'h00;
        n.oe_n = pins_s.dis;
        if (ld_ctl) begin
            n.ctl = pins_s.ctl;
        end
        if (ld_fill) begin
            n.fill = stl_pkg::stl_mask(pins_s.fill, r.ctl.wls);
        end
        if (ld_tx) begin
            n.hold = stl_pkg::stl_mask(pins_s.tx, r.ctl.wls);
            n.hold_valid = 1'b1;
            n.empty = 1'b0;
        end
        // clear first so a fill sent in the same cycle still sets the flag
        if (clr_fill) begin
            n.fill_sent = 1'b0;
        end
        // shift the next bit out at each bit time
        if (tick && r.state == stl_pkg::ST_DATA && r.left != 4'h0) begin
            n.line = r.shreg[0];
            n.shreg = {1'b0, r.shreg[7:1]};
            n.left = r.left - 4'h1;
            n.eoc_n = (r.left != 4'h1);
        end
        // line marks once the last bit is done and nothing follows
        if (char_end) begin
            ev[stl_pkg::EV_DONE] = 1'b1;
            n.state = stl_pkg::ST_IDLE;
            n.line = 1'b1;
            n.eoc_n = 1'b1;
        end
        if (take_hold) begin
            n.state = stl_pkg::ST_DATA;
            n.line = frame_hold[0];
            n.shreg = frame_hold[8:1];
            n.left = cnt - 4'h1;
            n.hold_valid = 1'b0;
            n.empty = 1'b1;
            ev[stl_pkg::EV_EMPTY] = 1'b1;
        end else if (take_fill) begin
            n.state = stl_pkg::ST_DATA;
            n.line = frame_fill[0];
            n.shreg = frame_fill[8:1];
            n.left = cnt - 4'h1;
            n.fill_sent = 1'b1;
            ev[stl_pkg::EV_FILL] = 1'b1;
        end
        if (init_ev) begin
            n.state = stl_pkg::ST_IDLE;
            n.left = 4'h0;
            n.hold_valid = 1'b0;
            n.eoc_n = 1'b1;
            n.empty = 1'b1;
            n.fill = stl_pkg::FILL_INIT;
            n.line = 1'b1;
        end
        // register port: write one to clear, a new event wins over the clear
        if (reg_wr && reg_addr == stl_pkg::ADDR_MASK) begin
            n.mask = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == stl_pkg::ADDR_STATUS) begin
            n.status = r.status & ~reg_wdata[2:0];
        end
        n.status = n.status | ev;
        if (reg_rd) begin
            case (reg_addr)
                stl_pkg::ADDR_STATUS: n.rdata = {5'h00, r.status};
                stl_pkg::ADDR_MASK: n.rdata = {5'h00, r.mask};
                stl_pkg::ADDR_STATE: n.rdata = {3'h0, r.state, r.hold_valid,
                    r.fill_sent, r.empty, r.line};
                default: n.rdata = 8'h00;
            endcase
        end
        // level interrupt follows the registered status and mask
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= stl_pkg::CORE_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign reg_rdata = r.rdata;
    assign serial_tx_out = r.line;
    assign end_of_char_n = r.eoc_n;
    assign tx_hold_empty = r.empty;
    assign tx_hold_empty_oe_n = r.oe_n;
    assign fill_sent_flag = r.fill_sent;
    assign fill_sent_flag_oe_n = r.oe_n;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_init_edge;
        !pins_s.init ##1 pins_s.init;
    endsequence

    sequence s_line_marks;
        r.state == stl_pkg::ST_IDLE && r.line && r.eoc_n;
    endsequence

    property p_init_idle;
        @(posedge clk) disable iff (!rstn)
        s_init_edge |=> s_line_marks ##1 !take_hold[*1];
    endproperty
    a_init_idle: assert property (p_init_idle) else $error("init did not idle");

    property p_init_flags;
        @(posedge clk) disable iff (!rstn)
        s_init_edge |=> r.empty && r.fill == stl_pkg::FILL_INIT && !r.hold_valid;
    endproperty
    a_init_flags: assert property (p_init_flags) else $error("init flags wrong");

    property p_tx_follow;
        @(posedge clk) disable iff (!rstn)
        ld_tx && !init_ev |=> !r.empty && r.hold_valid
            && r.hold == stl_pkg::stl_mask($past(pins_s.tx), $past(r.ctl.wls));
    endproperty
    a_tx_follow: assert property (p_tx_follow) else $error("hold not loaded");

    property p_tx_hold;
        @(posedge clk) disable iff (!rstn)
        !ld_tx && !init_ev |=> r.hold == $past(r.hold);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("hold changed");

    property p_fill_follow;
        @(posedge clk) disable iff (!rstn)
        ld_fill && !init_ev |=>
            r.fill == stl_pkg::stl_mask($past(pins_s.fill), $past(r.ctl.wls));
    endproperty
    a_fill_follow: assert property (p_fill_follow) else $error("fill not loaded");

    property p_disabled_ignore;
        @(posedge clk) disable iff (!rstn)
        pins_s.dis && !init_ev |=> $stable(r.fill) && $stable(r.hold) && $stable(r.ctl);
    endproperty
    a_disabled_ignore: assert property (p_disabled_ignore) else $error("input not ignored");

    property p_float;
        @(posedge clk) disable iff (!rstn)
        pins_s.dis |=> tx_hold_empty_oe_n && fill_sent_flag_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("flags not floated");

    property p_handover;
        @(posedge clk) disable iff (!rstn)
        take_hold |=> r.empty && !r.hold_valid && r.line == $past(frame_hold[0])
            && r.state == stl_pkg::ST_DATA;
    endproperty
    a_handover: assert property (p_handover) else $error("handover wrong");

    property p_fill_sent;
        @(posedge clk) disable iff (!rstn)
        take_fill |=> r.fill_sent && r.line == $past(frame_fill[0]);
    endproperty
    a_fill_sent: assert property (p_fill_sent) else $error("fill not sent");

    property p_short_word;
        @(posedge clk) disable iff (!rstn)
        ld_tx && !init_ev && r.ctl.wls == 2'h0 |=> r.hold[7:5] == 3'h0;
    endproperty
    a_short_word: assert property (p_short_word) else $error("high bits kept");
endmodule

// >>> dv/stl_host_model.sv
// host-side model: drives the load strobes, characters and selects of the transmitter
// assumes the transmitter clock; pins change by non-blocking assignment after rising edges
`timescale 1ns/1ns
module stl_host_model (
    input wire logic clk,
    output logic global_init,
    output logic output_float_ctrl,
    output logic tx_hold_load_strobe,
    output logic fill_hold_load_strobe,
    output logic fill_flag_clear,
    output logic control_reg_load,
    output logic clear_to_send,
    output logic [7:0] tx_char_in,
    output logic [7:0] fill_char_in,
    output logic [1:0] word_length_sel,
    output logic [1:0] clock_divide_sel,
    output logic [1:0] tx_mode_sel,
    output logic even_parity_sel,
    output logic parity_inhibit
);
    // ----------------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------------
    // disable held low
    initial begin
        global_init = 1'b0;
        output_float_ctrl = 1'b0;
        tx_hold_load_strobe = 1'b1;
        fill_hold_load_strobe = 1'b1;
        fill_flag_clear = 1'b1;
        control_reg_load = 1'b1;
        clear_to_send = 1'b0;
        tx_char_in = 8'h00;
        fill_char_in = 8'h00;
        word_length_sel = 2'h3;
        clock_divide_sel = 2'h0;
        tx_mode_sel = 2'h0;
        even_parity_sel = 1'b0;
        parity_inhibit = 1'b1;
    end

    // ----------------------------------------------------------------
    // host operations
    // ----------------------------------------------------------------
    // strobe low four cycles, data kept three more so the synchroniser sees it settled
    // every strobe idles high, so flipping it drops it
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: tx_hold_load_strobe <= ~tx_hold_load_strobe;
            1: fill_hold_load_strobe <= ~fill_hold_load_strobe;
            2: fill_flag_clear <= ~fill_flag_clear;
            default: control_reg_load <= ~control_reg_load;
        endcase
        repeat (4) @(posedge clk);
        tx_hold_load_strobe <= 1'b1;
        fill_hold_load_strobe <= 1'b1;
        fill_flag_clear <= 1'b1;
        control_reg_load <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // released data lines show the inverse, so a latch that keeps following is caught
    task automatic load_char(input logic [7:0] c);
        @(posedge clk);
        tx_char_in <= c;
        pulse(0);
        tx_char_in <= ~c;
    endtask

    task automatic load_fill(input logic [7:0] c);
        @(posedge clk);
        fill_char_in <= c;
        pulse(1);
        fill_char_in <= ~c;
    endtask

    // f holds mode select, even parity and parity inhibit, msb first
    task automatic load_ctl(input logic [1:0] wls, input logic [1:0] cs, input logic [3:0] f);
        @(posedge clk);
        word_length_sel <= wls;
        clock_divide_sel <= cs;
        {tx_mode_sel, even_parity_sel, parity_inhibit} <= f;
        pulse(3);
    endtask

    task automatic clear_flag();
        pulse(2);
    endtask

    task automatic pulse_init();
        @(posedge clk);
        global_init <= ~global_init;
        repeat (4) @(posedge clk);
        global_init <= ~global_init;
        repeat (4) @(posedge clk);
    endtask

    task automatic set_cts(input logic v);
        @(posedge clk);
        clear_to_send <= v;
    endtask

    task automatic set_disable(input logic v);
        @(posedge clk);
        output_float_ctrl <= v;
    endtask
endmodule

// >>> dv/sync_tx_load_reset_control_test.sv
// testbench of the transmitter load/reset block: register tasks plus serial capture
// assumes the host model drives every pin and the register port is driven here
`timescale 1ns/1ns
module sync_tx_load_reset_control_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic global_init, output_float_ctrl, tx_hold_load_strobe, fill_hold_load_strobe;
    logic fill_flag_clear, control_reg_load, clear_to_send, even_parity_sel, parity_inhibit;
    logic [7:0] tx_char_in, fill_char_in, reg_wdata, reg_rdata;
    logic [1:0] word_length_sel, clock_divide_sel, tx_mode_sel, reg_addr;
    logic reg_wr, reg_rd, serial_tx_out, end_of_char_n, tx_hold_empty, tx_hold_empty_oe_n;
    logic fill_sent_flag, fill_sent_flag_oe_n, irq;
    logic [15:0] bits, eoc_bits;
    int err_count = 0;
    int n_tests = 0;

    // 125 MHz
    always #4 clk = ~clk;

    stl_host_model host_u (.clk(clk), .global_init(global_init),
        .output_float_ctrl(output_float_ctrl), .tx_hold_load_strobe(tx_hold_load_strobe),
        .fill_hold_load_strobe(fill_hold_load_strobe), .fill_flag_clear(fill_flag_clear),
        .control_reg_load(control_reg_load), .clear_to_send(clear_to_send),
        .tx_char_in(tx_char_in), .fill_char_in(fill_char_in),
        .word_length_sel(word_length_sel), .clock_divide_sel(clock_divide_sel),
        .tx_mode_sel(tx_mode_sel), .even_parity_sel(even_parity_sel),
        .parity_inhibit(parity_inhibit));

    stl_core dut_u (.clk(clk), .rstn(rstn), .global_init(global_init),
        .output_float_ctrl(output_float_ctrl), .tx_hold_load_strobe(tx_hold_load_strobe),
        .fill_hold_load_strobe(fill_hold_load_strobe), .fill_flag_clear(fill_flag_clear),
        .control_reg_load(control_reg_load), .clear_to_send(clear_to_send),
        .tx_char_in(tx_char_in), .fill_char_in(fill_char_in),
        .word_length_sel(word_length_sel), .clock_divide_sel(clock_divide_sel),
        .tx_mode_sel(tx_mode_sel), .even_parity_sel(even_parity_sel),
        .parity_inhibit(parity_inhibit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_tx_out(serial_tx_out), .end_of_char_n(end_of_char_n),
        .tx_hold_empty(tx_hold_empty), .tx_hold_empty_oe_n(tx_hold_empty_oe_n),
        .fill_sent_flag(fill_sent_flag), .fill_sent_flag_oe_n(fill_sent_flag_oe_n), .irq(irq));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // sample a little after the edge so that edge's updates have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [1:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(name, {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    // start sending, find the handover edge, then sample each bit in its middle (16 clk/bit)
    task automatic send_capture(input int n, output logic [15:0] b);
        int k;
        b = 16'h0000;
        k = 0;
        host_u.set_cts(1'b1);
        while (tx_hold_empty !== 1'b1 && k < 100) begin
            wait_cyc(1);
            k++;
        end
        if (k >= 100) begin
            err_count++;
            print_verdict();
        end
        for (int i = 0; i < n; i++) begin
            wait_cyc(i == 0 ? 8 : 16);
            b[i] = serial_tx_out;
            eoc_bits[i] = end_of_char_n;
        end
        host_u.set_cts(1'b0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        wait_cyc(1);
        check("line and empty", 16'h3, {serial_tx_out, tx_hold_empty});
        reg_check(stl_pkg::ADDR_STATE, 8'h03, "state");
        reg_check(2'h3, 8'h00, "unmapped read");
        // character then the loaded fill character, lsb first
        host_u.load_ctl(stl_pkg::WLS_8, 2'h1, 4'h1);
        host_u.load_fill(8'h3c);
        host_u.load_char(8'ha5);
        wait_cyc(1);
        check("tx_hold_empty", 16'h0, tx_hold_empty);
        send_capture(16, bits);
        check("serial bits", 16'h3ca5, bits);
        check("fill_sent_flag", 16'h1, fill_sent_flag);
        check("end_of_char_n", 16'h7f7f, eoc_bits);
        // interrupt raised, masked and cleared once the line is quiet
        wait_cyc(400);
        reg_check(stl_pkg::ADDR_STATUS, 8'h07, "status");
        reg_write(stl_pkg::ADDR_MASK, 8'h00);
        wait_cyc(2);
        check("irq masked", 16'h0, irq);
        reg_write(stl_pkg::ADDR_MASK, 8'h02);
        wait_cyc(2);
        check("irq", 16'h1, irq);
        reg_check(stl_pkg::ADDR_MASK, 8'h02, "mask");
        reg_write(stl_pkg::ADDR_STATUS, 8'h07);
        wait_cyc(2);
        check("irq cleared", 16'h0, irq);
        reg_check(stl_pkg::ADDR_STATUS, 8'h00, "status");
        // chip disabled: flags float, loads and clears ignored
        host_u.set_disable(1'b1);
        wait_cyc(5);
        check("flag oe_n", 16'h3, {tx_hold_empty_oe_n, fill_sent_flag_oe_n});
        host_u.load_char(8'h11);
        host_u.load_fill(8'h99);
        host_u.clear_flag();
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= stl_pkg::ADDR_STATE;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check("state low bits", 16'h7, {12'h000, reg_rdata[3:0]});
        host_u.set_disable(1'b0);
        wait_cyc(5);
        check("flag oe_n", 16'h0, {tx_hold_empty_oe_n, fill_sent_flag_oe_n});
        host_u.load_char(8'h0f);
        send_capture(16, bits);
        check("serial bits", 16'h3c0f, bits);
        wait_cyc(20);
        host_u.clear_flag();
        wait_cyc(1);
        check("fill_sent_flag", 16'h0, fill_sent_flag);
        // init drops a waiting character and restores the fill of ones
        host_u.load_char(8'h42);
        wait_cyc(1);
        check("tx_hold_empty", 16'h0, tx_hold_empty);
        host_u.pulse_init();
        wait_cyc(1);
        check("line and empty", 16'h3, {serial_tx_out, tx_hold_empty});
        reg_check(stl_pkg::ADDR_STATE, 8'h03, "state");
        host_u.load_ctl(2'h0, 2'h1, 4'h1);
        host_u.load_char(8'he1);
        send_capture(10, bits);
        check("short bits", 16'h03e1, {6'h00, bits[9:0]});
        // non-sync mode, even parity: no fill follows, the line marks
        host_u.load_ctl(stl_pkg::WLS_8, 2'h1, 4'h6);
        host_u.load_fill(8'h00);
        host_u.load_char(8'h03);
        send_capture(12, bits);
        check("parity bits", 16'h0e03, {4'h0, bits[11:0]});
        print_verdict();
    end
endmodule
